// ### core/dmaec_top.sv
/*
 * dmaec_top: dma channel event control with apb registers and interrupt.
 * assumes an apb master on pclk; the transfer engine consumes start/abort
 * pulses and reports pattern matches as a one-cycle level.
 */
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dmaec_top
    import dmaec_pkg::*;
#(
    parameter int NIRQ = 256
) (
    // apb slave
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic                 pready,
    output logic                 pslverr,
    output logic [31:0]          prdata,
    // system interrupt sources and engine
    input  wire logic [NIRQ-1:0] irq_lines,
    input  wire logic            pat_match,
    output logic                 xfer_start,
    output logic                 xfer_abort,
    output logic                 channel_on,
    output logic                 channel_abort_flag,
    // interrupt to cpu
    output logic                 irq
);
    // elaboration check: the 8-bit selectors address exactly 256 lines
    if (NIRQ != 256) begin
        $error("NIRQ must be 256");
    end

    logic [7:0]      abort_irq_select_r;     // abort selector
    logic [7:0]      start_irq_select_r;     // start selector
    logic            pattern_abort_enable_r; // pattern abort enable
    logic            start_irq_enable_r;     // start enable
    logic            abort_irq_enable_r;     // abort enable
    logic [7:0]      pattern_byte_r;         // byte to match
    logic            channel_on_r;           // channel enable
    logic            abort_flag_r;           // set on any abort
    logic [EV_W-1:0] stat_r;                 // sticky events
    logic [EV_W-1:0] mask_r;                 // event mask
    logic            xfer_start_r;           // start pulse
    logic            xfer_abort_r;           // abort pulse
    logic [31:0]     prdata_r;               // registered read data
    logic            wr;                     // write taken this edge
    logic            rd;                     // read taken this edge
    logic            force_w;                // force strobe
    logic            abort_w;                // abort strobe
    logic [EV_W-1:0] ev;                     // events this cycle
    logic            any_abort;              // any abort cause

    dmaec_evt_if evt_bus ();

    // one access cycle, so every transfer ends at its first access edge
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;  // read sampled in setup so data is registered

    dmaec_evt_dec #(.NIRQ(NIRQ)) u_dec (
        .irq_lines (irq_lines),
        .start_sel (start_irq_select_r),
        .abort_sel (abort_irq_select_r),
        .start_en  (start_irq_enable_r),
        .abort_en  (abort_irq_enable_r),
        .pat_en    (pattern_abort_enable_r),
        .pat_match (pat_match),
        .evt       (evt_bus)
    );

    // write strobes carry no storage
    assign force_w   = wr && paddr == ECON_ADDR && pwdata[FORCE_BIT];
    assign abort_w   = wr && paddr == ECON_ADDR && pwdata[ABORT_BIT];
    assign any_abort = abort_w | evt_bus.abort_hit | evt_bus.pat_hit;
    assign ev        = {evt_bus.pat_hit, any_abort, force_w | evt_bus.start_hit};

    // event control fields; reserved bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_irq_select_r     <= AIRQ_RST;
            start_irq_select_r     <= SIRQ_RST;
            pattern_abort_enable_r <= 1'b0;
            start_irq_enable_r     <= 1'b0;
            abort_irq_enable_r     <= 1'b0;
        end else if (wr && paddr == ECON_ADDR) begin
            abort_irq_select_r     <= pwdata[AIRQ_LSB +: 8];
            start_irq_select_r     <= pwdata[SIRQ_LSB +: 8];
            pattern_abort_enable_r <= pwdata[PATTERN_ABORT_ENABLE_BIT];
            start_irq_enable_r     <= pwdata[START_IRQ_ENABLE_BIT];
            abort_irq_enable_r     <= pwdata[ABORT_IRQ_ENABLE_BIT];
        end
    end

    // pattern byte, only meaningful in pattern mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_byte_r <= PAT_RST;
        end else if (wr && paddr == PAT_ADDR) begin
            pattern_byte_r <= pwdata[7:0];
        end
    end

    // channel enable: pattern abort clears it and wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_on_r <= 1'b0;
        end else if (evt_bus.pat_hit) begin
            channel_on_r <= 1'b0;
        end else if (wr && paddr == CHCTL_ADDR) begin
            channel_on_r <= pwdata[0];
        end
    end

    // abort flag: set wins over a clearing write of bit 1 at CHCTL
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_flag_r <= 1'b0;
        end else if (any_abort) begin
            abort_flag_r <= 1'b1;
        end else if (wr && paddr == CHCTL_ADDR && pwdata[1]) begin
            abort_flag_r <= 1'b0;
        end
    end

    // registered pulses to the engine, high the cycle after each event cycle; a start is dropped when an abort comes in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_start_r <= 1'b0;
            xfer_abort_r <= 1'b0;
        end else begin
            xfer_start_r <= ev[EV_START] & ~any_abort;
            xfer_abort_r <= any_abort;
        end
    end

    // sticky status, write one to clear, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
        end else if (wr && paddr == IRQ_STAT_ADDR) begin
            stat_r <= (stat_r & ~pwdata[EV_W-1:0]) | ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr && paddr == IRQ_MASK_ADDR) begin
            mask_r <= pwdata[EV_W-1:0];
        end
    end

    // read mux; strobes and reserved bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (rd) begin
            if (paddr == ECON_ADDR) begin
                prdata_r <= {8'h00, abort_irq_select_r, start_irq_select_r, 2'b00,
                             pattern_abort_enable_r, start_irq_enable_r, abort_irq_enable_r, 3'b000};
            end else if (paddr == PAT_ADDR) begin
                prdata_r <= {24'h000000, pattern_byte_r};
            end else if (paddr == CHCTL_ADDR) begin
                prdata_r <= {30'h00000000, abort_flag_r, channel_on_r};
            end else if (paddr == IRQ_STAT_ADDR) begin
                prdata_r <= {29'h00000000, stat_r};
            end else if (paddr == IRQ_MASK_ADDR) begin
                prdata_r <= {29'h00000000, mask_r};
            end else begin
                prdata_r <= '0;  // unmapped reads zero
            end
        end
    end

    assign prdata             = prdata_r;
    assign xfer_start         = xfer_start_r;
    assign xfer_abort         = xfer_abort_r;
    assign channel_on         = channel_on_r;
    assign channel_abort_flag = abort_flag_r;
    assign irq                = |(stat_r & mask_r);
endmodule

// ### core/dmaec_pkg.sv
/*
 * dmaec_pkg: constants for the dma channel event control block.
 * assumes a 32-bit apb register bus and a 125 mhz pclk.
 */
package dmaec_pkg;
    // register byte addresses
    localparam logic [7:0]  ECON_ADDR      = 8'h00;  // channel_event_control
    localparam logic [7:0]  PAT_ADDR       = 8'h04;  // channel_pattern_byte
    localparam logic [7:0]  CHCTL_ADDR     = 8'h08;  // channel_on control
    localparam logic [7:0]  IRQ_STAT_ADDR  = 8'h0c;  // sticky event status
    localparam logic [7:0]  IRQ_MASK_ADDR  = 8'h10;  // event mask
    // field positions
    localparam int          AIRQ_LSB       = 16;
    localparam int          SIRQ_LSB       = 8;
    localparam int          FORCE_BIT      = 7;
    localparam int          ABORT_BIT      = 6;
    localparam int          PATTERN_ABORT_ENABLE_BIT      = 5;
    localparam int          START_IRQ_ENABLE_BIT     = 4;
    localparam int          ABORT_IRQ_ENABLE_BIT     = 3;
    // status bit positions
    localparam int          EV_START       = 0;
    localparam int          EV_ABORT       = 1;
    localparam int          EV_PATTERN     = 2;
    localparam int          EV_W           = 3;
    // reset values
    localparam logic [7:0]  AIRQ_RST       = 8'hff;
    localparam logic [7:0]  SIRQ_RST       = 8'hff;
    localparam logic [7:0]  PAT_RST        = 8'h00;
endpackage

// ### core/dmaec_evt_if.sv
/*
 * dmaec_evt_if: event pulses between the decoder and the register core.
 * assumes one pclk domain.
 */
`timescale 1ns/1ps
interface dmaec_evt_if;
    logic start_hit;   // selected start irq seen and enabled
    logic abort_hit;   // selected abort irq seen and enabled
    logic pat_hit;     // pattern match seen and enabled
    modport dec (output start_hit, output abort_hit, output pat_hit);
    modport core (input start_hit, input abort_hit, input pat_hit);
endinterface

// ### core/dmaec_evt_dec.sv
/*
 * dmaec_evt_dec: picks the selected irq lines and gates them with enables.
 * assumes irq lines are synchronous single-cycle or level requests.
 */
`timescale 1ns/1ps
module dmaec_evt_dec
    import dmaec_pkg::*;
#(
    parameter int NIRQ = 256
) (
    // irq sources and selections
    input  wire logic [NIRQ-1:0] irq_lines,
    input  wire logic [7:0]      start_sel,
    input  wire logic [7:0]      abort_sel,
    input  wire logic            start_en,
    input  wire logic            abort_en,
    input  wire logic            pat_en,
    input  wire logic            pat_match,
    // decoded events
    dmaec_evt_if.dec             evt
);
    // elaboration check: a narrower line set would leave selector codes dangling
    if (NIRQ != 256) begin
        $error("NIRQ must be 256 for 8-bit selectors");
    end
    // decoding of one selected line, used for both selectors
    function automatic logic pick(input logic [NIRQ-1:0] v, input logic [7:0] s);
        pick = v[s];
    endfunction
    // disabled selectors simply drop their line
    assign evt.start_hit = start_en & pick(irq_lines, start_sel);
    assign evt.abort_hit = abort_en & pick(irq_lines, abort_sel);
    assign evt.pat_hit   = pat_en & pat_match;
endmodule

// ### tb/dmaec_asserts.sv
/* dmaec_asserts: port checks for dmaec_top.
   assumes one pclk domain and one-cycle apb access phases. */
`timescale 1ns/1ps
module dmaec_asserts
    import dmaec_pkg::*;
#(
    parameter int NIRQ = 256
) (
    // apb side
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    // event side
    input wire logic [NIRQ-1:0] irq_lines,
    input wire logic            pat_match,
    input wire logic            xfer_start,
    input wire logic            xfer_abort,
    input wire logic            channel_on,
    input wire logic            channel_abort_flag
);
    logic [7:0] asel_r;  // shadow abort selector
    logic [7:0] ssel_r;  // shadow start selector
    logic [2:0] en_r;    // shadow enables: pattern, start, abort
    wire        wr_e = psel & penable & pwrite & (paddr == ECON_ADDR);
    wire        rd_e = psel & !penable & !pwrite & (paddr == ECON_ADDR);
    // causes use the old enables, as the write lands on the same edge
    wire        ab_c = (irq_lines[asel_r] & en_r[0]) | (pat_match & en_r[2]) | (wr_e & pwdata[6]);
    wire        st_c = (irq_lines[ssel_r] & en_r[1]) | (wr_e & pwdata[7]);
    // shadow of the event control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asel_r <= 8'hff;
            ssel_r <= 8'hff;
            en_r   <= 3'h0;
        end else if (wr_e) begin
            asel_r <= pwdata[23:16];
            ssel_r <= pwdata[15:8];
            en_r   <= pwdata[5:3];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_start_go: assert property (st_c && !ab_c |=> xfer_start)
        else $error("start pulse missing");
    a_start_quiet: assert property (!st_c |=> !xfer_start)
        else $error("stray start pulse");
    a_abort_go: assert property (ab_c |=> xfer_abort)
        else $error("abort pulse missing");
    a_abort_quiet: assert property (!ab_c |=> !xfer_abort)
        else $error("stray abort pulse");
    a_flag_set: assert property (ab_c |=> channel_abort_flag)
        else $error("abort flag not set");
    a_pat_off: assert property (pat_match && en_r[2] |=> !channel_on)
        else $error("channel stays on");
    a_econ_zero: assert property (rd_e |=> prdata[31:24] == 8'h00 && prdata[7:6] == 2'h0 &&
        prdata[2:0] == 3'h0)
        else $error("event control reserved bits set");
    a_econ_fields: assert property (rd_e |=> prdata[23:8] == {asel_r, ssel_r} && prdata[5:3] == en_r)
        else $error("event control fields wrong");
    a_pat_upper: assert property (psel && !penable && !pwrite && paddr == PAT_ADDR |=>
        prdata[31:8] == 24'h0)
        else $error("pattern upper bits set");
endmodule

// ### tb/dmaec_partner.sv
/* dmaec_partner: irq sources and engine match report for dmaec_top.
   fires one pulse dly cycles after req; code bit 8 picks the pattern match. */
`timescale 1ns/1ps
module dmaec_partner #(
    parameter int NIRQ = 256
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            req,
    input wire logic [8:0]      code,
    input wire logic [3:0]      dly,
    output logic [NIRQ-1:0]     irq_lines,
    output logic                pat_match
);
    logic [3:0] cnt_r;   // cycles left before the pulse
    logic [8:0] code_r;  // held request
    // a slow source is modelled by a long dly; lines idle low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= 4'h0;
            code_r    <= 9'h000;
            irq_lines <= '0;
            pat_match <= 1'b0;
        end else begin
            irq_lines <= '0;
            pat_match <= 1'b0;
            if (req) begin
                cnt_r  <= dly;
                code_r <= code;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
            if (cnt_r == 4'h1 && code_r[8]) begin
                pat_match <= 1'b1;
            end else if (cnt_r == 4'h1) begin
                irq_lines[code_r[7:0]] <= 1'b1;
            end
        end
    end
endmodule

// ### tb/dma_channel_event_control_tb.sv
/* dma_channel_event_control_tb: apb master, partner and checks for dmaec_top.
   assumes pready answers; reads are checked through a queue. */
`timescale 1ns/1ps
module dma_channel_event_control_tb
    import dmaec_pkg::*;
;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req = 0;
    logic [7:0]   paddr = 8'h00, a, s;
    logic [31:0]  pwdata = 32'h0, prdata, lf = 32'h1034;
    logic [8:0]   code = 9'h0;
    logic [3:0]   dly = 4'h1;
    logic [255:0] irq_lines;
    logic         pready, pslverr, pat_match, xfer_start, xfer_abort, channel_on, channel_abort_flag, irq;
    logic [31:0]  exp_q[$];  // expected read words, oldest first
    int           miscompares = 0, cmp_count = 0, n_st = 0, n_ab = 0, e_st = 0, e_ab = 0;
    always #4 pclk = ~pclk;
    dmaec_top #(.NIRQ(256)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .irq_lines, .pat_match, .xfer_start, .xfer_abort, .channel_on, .channel_abort_flag, .irq);
    dmaec_partner #(.NIRQ(256)) far (.pclk, .presetn, .req, .code, .dly, .irq_lines, .pat_match);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: the next call never reassigns psel in the same step, and outputs settle
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    // partner request with a random delay, then settle
    task automatic fire(input logic [8:0] c);
        code <= c;
        dly <= lf[3:0] | 4'h1;
        req <= 1'b1;
        lf = lfsr(lf);
        @(posedge pclk);
        req <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask
    task automatic counts();
        repeat (3) @(posedge pclk);
        chk("starts", e_st, n_st);
        chk("aborts", e_ab, n_ab);
    endtask
    // monitor: read data at the access edge, pulse counts
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            chk("prdata", exp_q.pop_front(), prdata);
        end
        if (psel && penable && pready) begin
            chk("pslverr", 32'h0, {31'h0, pslverr});
        end
        n_st += (xfer_start === 1'b1);
        n_ab += (xfer_abort === 1'b1);
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ECON_ADDR, 32'h00ffff00);
        rd(PAT_ADDR, 32'h0);
        apb(1'b1, ECON_ADDR, 32'hffffffff);
        e_ab++;
        rd(ECON_ADDR, 32'h00ffff38);
        counts();
        $display("test reset and fields done");
        for (int i = 0; i < 4; i++) begin
            a = lf[7:0];
            s = (lf[15:8] == a) ? ~a : lf[15:8];
            apb(1'b1, ECON_ADDR, {8'h00, a, s, 8'h18});
            rd(ECON_ADDR, {8'h00, a, s, 8'h18});
            fire({1'b0, s});
            e_st++;
            fire({1'b0, a});
            e_ab++;
            counts();
            apb(1'b1, ECON_ADDR, {8'h00, a, s, 8'h00});
            fire({1'b0, s});
            fire({1'b0, a});
            counts();
        end
        $display("test irq select done");
        apb(1'b1, PAT_ADDR, lf);
        rd(PAT_ADDR, {24'h0, lf[7:0]});
        apb(1'b1, CHCTL_ADDR, 32'h1);
        apb(1'b1, ECON_ADDR, 32'h20);
        fire(9'h100);
        e_ab++;
        counts();
        chk("channel_on", 32'h0, {31'h0, channel_on});
        apb(1'b1, ECON_ADDR, 32'h0);
        apb(1'b1, CHCTL_ADDR, 32'h1);
        fire(9'h100);
        counts();
        chk("channel_on", 32'h1, {31'h0, channel_on});
        $display("test pattern done");
        apb(1'b1, ECON_ADDR, 32'h80);
        apb(1'b1, ECON_ADDR, 32'h40);
        e_st++;
        e_ab++;
        counts();
        // flag still set from the aborts, channel still on; write one clears the flag
        rd(CHCTL_ADDR, 32'h3);
        apb(1'b1, CHCTL_ADDR, 32'h2);
        rd(CHCTL_ADDR, 32'h0);
        $display("test strobes done");
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, IRQ_MASK_ADDR, 32'h7);
        chk("irq", 32'h1, {31'h0, irq});
        rd(IRQ_STAT_ADDR, 32'h7);
        apb(1'b1, IRQ_STAT_ADDR, 32'h7);
        chk("irq", 32'h0, {31'h0, irq});
        rd(IRQ_STAT_ADDR, 32'h0);
        rd(8'h14, 32'h0);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule
bind dmaec_top dmaec_asserts #(.NIRQ(NIRQ)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .irq_lines, .pat_match, .xfer_start, .xfer_abort, .channel_on, .channel_abort_flag);
